// ===== core/frontend_control_registers.sv
/*
 * Control register bank of a dual channel receive front end, reached over
 * a four or three wire serial port, with the receive control outputs.
 * Receive bus formatting sits in a submodule; this file owns the serial
 * port, the register map and the soft reset.
 * Assumes serial clock, select and data inputs are synchronous to clk and
 * the serial clock runs at most at a quarter of clk.
 */
`timescale 1ns/1ps
`default_nettype none

`include "frontend_consts.svh"

module frontend_control_registers #(
	parameter int         W        = 12,
	parameter logic [7:0] REVISION = 8'h01 // Arbitrary revision code
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         sclk,
	input  wire logic         sel_n,
	input  wire logic         sdio_in,
	output logic              sdio_out,
	output logic              sdio_oe,
	output logic              serial_data_out_pin,
	output logic              serial_data_out_oe,
	output logic              dll_relock,
	output logic              pdn_diff_reference,
	output logic              pdn_reference,
	output logic              pdn_rx_digital,
	output logic              pdn_channel_b,
	output logic              pdn_channel_a,
	output logic              pdn_buffer_b,
	output logic              pdn_buffer_a,
	output logic              pdn_rx_all,
	output logic              bypass_buffer_a,
	output logic              bypass_buffer_b,
	output logic      [4:0]   receive_gain_code_a,
	output logic      [4:0]   receive_gain_code_b,
	output logic              duty_cycle_stabilizer,
	output logic              shared_reference,
	output logic              high_speed_duty_opt,
	output logic              second_output_clock_sel,
	input  wire logic [W-1:0] adc_a,
	input  wire logic [W-1:0] adc_b,
	output logic      [W-1:0] rx_bus_a,
	output logic      [W-1:0] rx_bus_b,
	output logic              rx_bus_oe,
	output logic              receive_channel_indicator,
	output logic              indicator_oe
);

	frontend_pkg::ctrl_state_t st_r;
	frontend_pkg::ctrl_state_t st_nxt;

	logic       rise;
	logic       fall;
	logic       bidir;
	logic       lsb_first;
	logic [2:0] pos;
	logic [5:0] addr;
	logic [7:0] wbyte;
	logic [7:0] clamped;
	logic [7:0]      pdn_bits;
	logic [1:0]      chan_bypass;
	logic [1:0][4:0] chan_gain;

	function automatic logic [7:0] write_mask(input logic [5:0] a);
		// Read-only and unmapped offsets take no write bits at all
		case (a)
			`OFS_GENERAL:      write_mask = `MASK_GENERAL;
			`OFS_RX_PWRDN:     write_mask = `MASK_FULL;
			`OFS_RX_A_SETUP:   write_mask = `MASK_RX_SETUP;
			`OFS_RX_B_SETUP:   write_mask = `MASK_RX_SETUP;
			`OFS_RX_MISC:      write_mask = `MASK_RX_MISC;
			`OFS_RX_IF:        write_mask = `MASK_RX_IF;
			`OFS_AUX_CTRL:     write_mask = `MASK_FULL;
			`OFS_AUX_CLOCK:    write_mask = `MASK_FULL;
			`OFS_AUX_OUT_A:    write_mask = `MASK_FULL;
			`OFS_AUX_OUT_2:    write_mask = `MASK_FULL;
			`OFS_AUX_OUT_3:    write_mask = `MASK_FULL;
			`OFS_AUX_UPDATE:   write_mask = `MASK_FULL;
			`OFS_AUX_POWER:    write_mask = `MASK_FULL;
			`OFS_AUX_INVERT:   write_mask = `MASK_FULL;
			`OFS_SIGMA_DELTA_WORD_HIGH_LOW:  write_mask = `MASK_FULL;
			`OFS_SIGMA_DELTA_WORD_HIGH_HIGH: write_mask = `MASK_FULL;
			`OFS_RX_LOW_POWER: write_mask = `MASK_FULL;
			default:           write_mask = 8'h00;
		endcase
	endfunction : write_mask

	// Masking here keeps a careless host from setting a bit that has no
	// hardware behind it
	function automatic logic [7:0] filter_write(
		input logic [5:0] a,
		input logic [7:0] d
	);
		logic [7:0] f;
		f = d & write_mask(a);
		// Codes above the top step are held at the top step
		if ((a == `OFS_RX_A_SETUP || a == `OFS_RX_B_SETUP)
			&& f[`GAIN_MSB:0] > `GAIN_MAX)
			f[`GAIN_MSB:0] = `GAIN_MAX;
		filter_write = f;
	endfunction : filter_write

	// Defaults of the whole map; unmapped entries stay zero for ever
	function automatic logic [63:0][7:0] default_regs();
		logic [63:0][7:0] r;
		r = '0;
		for (int i = 0; i < 64; i++)
			r[i] = `RST_OTHER;
		r[`OFS_GENERAL] = `RST_GENERAL;
		r[`OFS_RX_PWRDN] = `RST_RX_PWRDN;
		r[`OFS_RX_A_SETUP] = `RST_RX_SETUP;
		r[`OFS_RX_B_SETUP] = `RST_RX_SETUP;
		r[`OFS_RX_MISC] = `RST_RX_MISC;
		r[`OFS_RX_IF] = `RST_RX_IF;
		default_regs = r;
	endfunction : default_regs

	function automatic logic [7:0] read_value(
		input logic [63:0][7:0] r,
		input logic [5:0]       a
	);
		if (a == `OFS_CHIP_REV)
			read_value = REVISION;
		else
			read_value = r[a];
	endfunction : read_value

	// Serial port options apply from the next frame, as they are taken
	// from the committed register, never from a half received byte
	assign bidir = st_r.regs[`OFS_GENERAL][`BIT_BIDIR];
	assign lsb_first = st_r.regs[`OFS_GENERAL][`BIT_LSB_FIRST];

	always_comb
	begin
		rise = sclk & ~st_r.sclk_q;
		fall = ~sclk & st_r.sclk_q;
		// First bit on the wire lands in bit 7, or in bit 0 when reversed
		pos = lsb_first ? st_r.cnt : 3'h7 - st_r.cnt;
		addr = st_r.instr[5:0];
		wbyte = st_r.wdata;
		wbyte[pos] = sdio_in;
		clamped = filter_write(addr, wbyte);

		// Everything holds unless a high select or a serial clock edge moves it; relock drops after one cycle
		st_nxt = st_r;
		st_nxt.sclk_q = sclk;
		st_nxt.relock = 1'b0;

		// A frame cut short by the select never commits its byte
		if (sel_n)
		begin
			st_nxt.phase = frontend_pkg::PH_INSTR;
			st_nxt.cnt = 3'h0;
			st_nxt.instr = 8'h00;
			st_nxt.wdata = 8'h00;
			st_nxt.reading = 1'b0;
			st_nxt.sdio_oe = 1'b0;
			st_nxt.sdo_oe = 1'b0;
		end
		else
		begin
			case (st_r.phase)
				frontend_pkg::PH_INSTR:
				begin
					if (rise)
					begin
						st_nxt.instr[pos] = sdio_in;
						st_nxt.cnt = st_r.cnt + 3'h1;
						if (st_r.cnt == 3'h7)
						begin
							st_nxt.phase = frontend_pkg::PH_DATA;
							st_nxt.reading =
								st_nxt.instr[`BIT_INSTR_READ];
							st_nxt.rdata = read_value(st_r.regs,
								st_nxt.instr[5:0]);
						end
					end
				end
				frontend_pkg::PH_DATA:
				begin
					// Read data moves on the falling edge so the host
					// can sample it on the next rising edge
					if (fall && st_r.reading)
					begin
						if (bidir)
						begin
							st_nxt.sdio_out = st_r.rdata[pos];
							st_nxt.sdio_oe = 1'b1;
							st_nxt.sdo_oe = 1'b0;
						end
						else
						begin
							st_nxt.sdo_out = st_r.rdata[pos];
							st_nxt.sdo_oe = 1'b1;
							st_nxt.sdio_oe = 1'b0;
						end
					end
					if (rise)
					begin
						st_nxt.wdata = wbyte;
						st_nxt.cnt = st_r.cnt + 3'h1;
						if (st_r.cnt == 3'h7)
						begin
							st_nxt.phase = frontend_pkg::PH_HOLD;
							if (!st_r.reading)
							begin
								// Registers change only once all
								// sixteen bits are in
								if (addr == `OFS_GENERAL
									&& wbyte[`BIT_SOFT_RESET])
								begin
									st_nxt.regs = default_regs();
									st_nxt.relock = 1'b1;
								end
								else
								begin
									// Soft reset bit is masked out
									// and so never stays set
									st_nxt.regs[addr] = clamped;
								end
							end
						end
					end
				end
				frontend_pkg::PH_HOLD:
				begin
					// Extra clocks in a frame are ignored; the line is
					// let go after the last read bit has been sampled
					if (fall)
					begin
						st_nxt.sdio_oe = 1'b0;
						st_nxt.sdo_oe = 1'b0;
					end
				end
				default:
				begin
					st_nxt.phase = frontend_pkg::PH_INSTR;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			// Power-up reset loads the same defaults as a soft reset
			st_r <= '0;
			st_r.regs <= default_regs();
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Data pins and their enables come straight from flops, free of glitches
	assign sdio_out = st_r.sdio_out;
	assign sdio_oe = st_r.sdio_oe;
	assign serial_data_out_pin = st_r.sdo_out;
	assign serial_data_out_oe = st_r.sdo_oe;
	assign dll_relock = st_r.relock;

	// Each power-down control is active high, one register bit apiece
	assign pdn_bits = st_r.regs[`OFS_RX_PWRDN];
	assign pdn_diff_reference = pdn_bits[`BIT_PDN_DIFF_REF];
	assign pdn_reference = pdn_bits[`BIT_PDN_REF];
	assign pdn_rx_digital = pdn_bits[`BIT_PDN_DIGITAL];
	assign pdn_channel_b = pdn_bits[`BIT_PDN_CHAN_B];
	assign pdn_channel_a = pdn_bits[`BIT_PDN_CHAN_A];
	assign pdn_buffer_b = pdn_bits[`BIT_PDN_BUF_B];
	assign pdn_buffer_a = pdn_bits[`BIT_PDN_BUF_A];
	assign pdn_rx_all = pdn_bits[`BIT_PDN_ALL];

	// Buffer power stays under software; bypass alone does not force it.
	// Channel B's setup register sits right after channel A's.
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		assign chan_bypass[ch] =
			st_r.regs[`OFS_RX_A_SETUP + ch][`BIT_BYPASS];
		assign chan_gain[ch] =
			st_r.regs[`OFS_RX_A_SETUP + ch][`GAIN_MSB:0];
	end

	assign bypass_buffer_a = chan_bypass[0];
	assign bypass_buffer_b = chan_bypass[1];
	assign receive_gain_code_a = chan_gain[0];
	assign receive_gain_code_b = chan_gain[1];

	assign duty_cycle_stabilizer =
		st_r.regs[`OFS_RX_MISC][`BIT_DCS];
	assign shared_reference =
		st_r.regs[`OFS_RX_MISC][`BIT_SHARED_REF];
	assign high_speed_duty_opt =
		st_r.regs[`OFS_RX_MISC][`BIT_HS_DUTY];
	assign second_output_clock_sel =
		st_r.regs[`OFS_RX_IF][`BIT_RETIME];

	// The formatter registers samples, so the buses lag the inputs one clk
	rx_output_formatter #(
		.W (W)
	) u_fmt (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.adc_a        (adc_a),
		.adc_b        (adc_b),
		.three_state  (st_r.regs[`OFS_RX_IF][`BIT_THREE_STATE]),
		.twos_comp    (st_r.regs[`OFS_RX_IF][`BIT_TWOS_COMP]),
		.ind_invert   (st_r.regs[`OFS_RX_IF][`BIT_INV_IND]),
		.mux_mode     (st_r.regs[`OFS_RX_IF][`BIT_MUX_OUT]),
		.bus_a        (rx_bus_a),
		.bus_b        (rx_bus_b),
		.bus_oe       (rx_bus_oe),
		.indicator    (receive_channel_indicator),
		.indicator_oe (indicator_oe)
	);

endmodule : frontend_control_registers

`default_nettype wire

// ===== core/frontend_consts.svh
/*
 * Register offsets, field positions, write masks and reset values of the
 * front end control register bank.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef FRONTEND_CONSTS_SVH
`define FRONTEND_CONSTS_SVH

`define OFS_GENERAL      6'h00
`define OFS_RX_PWRDN     6'h01
`define OFS_RX_A_SETUP   6'h02
`define OFS_RX_B_SETUP   6'h03
`define OFS_RX_MISC      6'h04
`define OFS_RX_IF        6'h05
`define OFS_AUX_B1_LOW   6'h20
`define OFS_AUX_B1_HIGH  6'h21
`define OFS_AUX_CTRL     6'h22
`define OFS_AUX_CLOCK    6'h23
`define OFS_AUX_OUT_A    6'h24
`define OFS_AUX_OUT_2    6'h25
`define OFS_AUX_OUT_3    6'h26
`define OFS_AUX_UPDATE   6'h27
`define OFS_AUX_POWER    6'h28
`define OFS_AUX_INVERT   6'h29
`define OFS_SIGMA_DELTA_WORD_HIGH_LOW  6'h2a
`define OFS_SIGMA_DELTA_WORD_HIGH_HIGH 6'h2b
`define OFS_RX_LOW_POWER 6'h31
`define OFS_CHIP_REV     6'h3f

`define BIT_BIDIR        7
`define BIT_LSB_FIRST    6
`define BIT_SOFT_RESET   5
`define BIT_THREE_STATE  4
`define BIT_RETIME       3
`define BIT_TWOS_COMP    2
`define BIT_INV_IND      1
`define BIT_MUX_OUT      0
`define BIT_BYPASS       7
`define BIT_HS_DUTY      2
`define BIT_SHARED_REF   1
`define BIT_DCS          0
`define BIT_INSTR_READ   7
`define BIT_PDN_DIFF_REF 7
`define BIT_PDN_REF      6
`define BIT_PDN_DIGITAL  5
`define BIT_PDN_CHAN_B   4
`define BIT_PDN_CHAN_A   3
`define BIT_PDN_BUF_B    2
`define BIT_PDN_BUF_A    1
`define BIT_PDN_ALL      0
`define GAIN_MSB         4

`define MASK_GENERAL     8'hc0
`define MASK_RX_SETUP    8'h9f
`define MASK_RX_MISC     8'h07
`define MASK_RX_IF       8'h1f
`define MASK_FULL        8'hff

`define RST_GENERAL      8'h00
`define RST_RX_PWRDN     8'h00
`define RST_RX_SETUP     8'h00
`define RST_RX_MISC      8'h00
`define RST_RX_IF        8'h00
`define RST_OTHER        8'h00

`define GAIN_MAX         5'h14
`define BITS_PER_BYTE    4'h8

`endif

// ===== core/frontend_pkg.sv
/*
 * Types of the control register bank; its output formatter keeps its own.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package frontend_pkg;

	typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_HOLD} spi_phase_t;

	typedef struct packed {
		logic             sclk_q;
		spi_phase_t       phase;
		logic [2:0]       cnt;
		logic [7:0]       instr;
		logic [7:0]       wdata;
		logic [7:0]       rdata;
		logic             reading;
		logic             sdio_out;
		logic             sdio_oe;
		logic             sdo_out;
		logic             sdo_oe;
		logic             relock;
		logic [63:0][7:0] regs;
	} ctrl_state_t;

endpackage : frontend_pkg

// ===== core/rx_output_formatter.sv
/*
 * Receive output formatter: number format, multiplexed or dual port output,
 * channel indicator and high impedance control of the receive data buses.
 * Assumes converter samples arrive synchronous to clk, one pair per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module rx_output_formatter #(
	parameter int W = 12
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] adc_a,
	input  wire logic [W-1:0] adc_b,
	input  wire logic         three_state,
	input  wire logic         twos_comp,
	input  wire logic         ind_invert,
	input  wire logic         mux_mode,
	output logic      [W-1:0] bus_a,
	output logic      [W-1:0] bus_b,
	output logic              bus_oe,
	output logic              indicator,
	output logic              indicator_oe
);

	typedef struct packed {
		logic         phase_b;
		logic [W-1:0] a;
		logic [W-1:0] b;
		logic         oe;
		logic         ind;
	} fmt_state_t;

	fmt_state_t st_r;
	fmt_state_t st_nxt;
	logic [W-1:0] fa;
	logic [W-1:0] fb;

	always_comb
	begin
		// Flipping the sign bit turns offset binary into two's complement
		fa = twos_comp ? {~adc_a[W-1], adc_a[W-2:0]} : adc_a;
		fb = twos_comp ? {~adc_b[W-1], adc_b[W-2:0]} : adc_b;
		st_nxt = st_r;
		st_nxt.oe = ~three_state;
		if (mux_mode)
		begin
			st_nxt.phase_b = ~st_r.phase_b;
			st_nxt.a = st_r.phase_b ? fb : fa;
			st_nxt.b = '0;
			st_nxt.ind = ~st_r.phase_b ^ ind_invert;
		end
		else
		begin
			st_nxt.phase_b = 1'b0;
			st_nxt.a = fa;
			st_nxt.b = fb;
			st_nxt.ind = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign bus_a = st_r.a;
	assign bus_b = st_r.b;
	assign bus_oe = st_r.oe;
	assign indicator = st_r.ind;
	assign indicator_oe = st_r.oe;

endmodule : rx_output_formatter

`default_nettype wire

// ===== sim/frontend_checker.sv
/*
 * Port assertions for the front end control register bank.
 * Assumes it is bound to frontend_control_registers.
 */
`timescale 1ns/1ps
`default_nettype none

module frontend_checker #(
	parameter int W = 12
) (
	input wire logic         clk,
	input wire logic         sys_rst,
	input wire logic         sclk,
	input wire logic         sel_n,
	input wire logic         sdio_oe,
	input wire logic         serial_data_out_oe,
	input wire logic         dll_relock,
	input wire logic         pdn_diff_reference,
	input wire logic         pdn_reference,
	input wire logic         pdn_rx_digital,
	input wire logic         pdn_channel_b,
	input wire logic         pdn_channel_a,
	input wire logic         pdn_buffer_b,
	input wire logic         pdn_buffer_a,
	input wire logic         pdn_rx_all,
	input wire logic         bypass_buffer_a,
	input wire logic         bypass_buffer_b,
	input wire logic [4:0]   receive_gain_code_a,
	input wire logic [4:0]   receive_gain_code_b,
	input wire logic         duty_cycle_stabilizer,
	input wire logic         shared_reference,
	input wire logic         high_speed_duty_opt,
	input wire logic         second_output_clock_sel,
	input wire logic [W-1:0] adc_b,
	input wire logic [W-1:0] rx_bus_b,
	input wire logic         rx_bus_oe,
	input wire logic         receive_channel_indicator,
	input wire logic         indicator_oe
);
	logic [23:0] ctrl;

	assign ctrl = {pdn_diff_reference, pdn_reference, pdn_rx_digital,
		pdn_channel_b, pdn_channel_a, pdn_buffer_b, pdn_buffer_a,
		pdn_rx_all, bypass_buffer_a, bypass_buffer_b, receive_gain_code_a,
		receive_gain_code_b, duty_cycle_stabilizer, shared_reference,
		high_speed_duty_opt, second_output_clock_sel};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	AST_RESET_CLEAR: assert property ($fell(sys_rst) |-> ctrl == '0)
		else $error("controls not clear after reset");
	AST_SOFT_CLEAR: assert property (dll_relock |-> ##[0:2] ctrl == '0)
		else $error("soft reset left controls set");
	AST_RELOCK_ONE: assert property (dll_relock |=> !dll_relock)
		else $error("relock pulse longer than one cycle");
	AST_GAIN_MAX: assert property (receive_gain_code_a <= 5'h14 && receive_gain_code_b <= 5'h14)
		else $error("gain code above maximum");
	AST_COMMIT: assert property ($changed(ctrl) |-> !sel_n && sclk)
		else $error("controls changed outside a write commit");
	AST_FLOAT: assert property (indicator_oe == rx_bus_oe)
		else $error("indicator enable differs from bus enable");
	AST_DUAL_IND: assert property (rx_bus_oe && rx_bus_b != '0 |-> !receive_channel_indicator)
		else $error("indicator active in dual port mode");
	AST_LOW_BITS: assert property (rx_bus_oe && rx_bus_b != '0 |-> rx_bus_b[W-2:0] == $past(adc_b[W-2:0]))
		else $error("bus b low bits wrong");
	AST_ONE_PIN: assert property (!(sdio_oe && serial_data_out_oe))
		else $error("both data pins driven");
	AST_IDLE_PINS: assert property (sel_n [*2] |-> !sdio_oe && !serial_data_out_oe)
		else $error("data pin driven outside a frame");

	cover property (dll_relock);
	cover property (sdio_oe);
	cover property (rx_bus_oe && rx_bus_b == '0 && receive_channel_indicator);
endmodule : frontend_checker

bind frontend_control_registers frontend_checker #(
	.W (W)
) u_chk (
	.clk                       (clk),
	.sys_rst                   (sys_rst),
	.sclk                      (sclk),
	.sel_n                     (sel_n),
	.sdio_oe                   (sdio_oe),
	.serial_data_out_oe        (serial_data_out_oe),
	.dll_relock                (dll_relock),
	.pdn_diff_reference        (pdn_diff_reference),
	.pdn_reference             (pdn_reference),
	.pdn_rx_digital            (pdn_rx_digital),
	.pdn_channel_b             (pdn_channel_b),
	.pdn_channel_a             (pdn_channel_a),
	.pdn_buffer_b              (pdn_buffer_b),
	.pdn_buffer_a              (pdn_buffer_a),
	.pdn_rx_all                (pdn_rx_all),
	.bypass_buffer_a           (bypass_buffer_a),
	.bypass_buffer_b           (bypass_buffer_b),
	.receive_gain_code_a       (receive_gain_code_a),
	.receive_gain_code_b       (receive_gain_code_b),
	.duty_cycle_stabilizer     (duty_cycle_stabilizer),
	.shared_reference          (shared_reference),
	.high_speed_duty_opt       (high_speed_duty_opt),
	.second_output_clock_sel   (second_output_clock_sel),
	.adc_b                     (adc_b),
	.rx_bus_b                  (rx_bus_b),
	.rx_bus_oe                 (rx_bus_oe),
	.receive_channel_indicator (receive_channel_indicator),
	.indicator_oe              (indicator_oe)
);

`default_nettype wire

// ===== sim/frontend_host.sv
/*
 * Host model of the serial control port: frames on task calls.
 * Assumes clk is the device clock and sclk halves of at least 2 cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module frontend_host (
	input  wire logic clk,
	input  wire logic sdio_out,
	input  wire logic sdio_oe,
	input  wire logic serial_data_out_pin,
	input  wire logic serial_data_out_oe,
	output logic      sclk,
	output logic      sel_n,
	output logic      sdio_in
);
	logic drv, hd, last, lsb, bidir;
	int   half;

	// Released line toggles so a stale value never reads as valid
	assign sdio_in = sdio_oe ? sdio_out : drv ? hd : ~last;

	always @(posedge clk)
		last <= sdio_in;

	initial
	begin
		{sclk, sel_n, drv, hd, lsb, bidir} = 6'b011000;
		half = 2;
	end

	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt

	// Fewer than 16 bits aborts the frame
	task xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
		input int nb, output logic [7:0] q);
		logic [15:0] w;
		w = {rd, 1'b0, a, d};
		q = 'x;
		sel_n = 1'b0;
		for (int k = 0; k < nb; k++)
		begin
			hd = lsb ? w[k < 8 ? 8 + k : k - 8] : w[15 - k];
			drv = !(rd && bidir && k > 7);
			wt(half);
			sclk = 1'b1;
			if (rd && k > 7)
				q[lsb ? k - 8 : 15 - k] = bidir ? sdio_in :
					serial_data_out_oe ? serial_data_out_pin : 1'bx;
			wt(half);
			sclk = 1'b0;
		end
		wt(half);
		sel_n = 1'b1;
		drv = 1'b1;
		if (nb == 16 && !rd && a == 6'h00)
			{bidir, lsb} = d[5] ? 2'b00 : d[7:6];
		wt(2);
	endtask : xfer
endmodule : frontend_host

`default_nettype wire

// ===== sim/frontend_control_registers_test.sv
/*
 * Self-checking bench of the control register bank.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`default_nettype none

module frontend_control_registers_test;
	localparam int W = 12;
	localparam logic [7:0] REV = 8'h5a; // Arbitrary revision value
	logic clk, sys_rst, sclk, sel_n, sdio_in, sdio_out, sdio_oe;
	logic serial_data_out_pin, serial_data_out_oe, dll_relock;
	logic pdn_diff_reference, pdn_reference, pdn_rx_digital, pdn_channel_b;
	logic pdn_channel_a, pdn_buffer_b, pdn_buffer_a, pdn_rx_all;
	logic bypass_buffer_a, bypass_buffer_b, duty_cycle_stabilizer;
	logic shared_reference, high_speed_duty_opt, second_output_clock_sel;
	logic [4:0]   receive_gain_code_a, receive_gain_code_b;
	logic [W-1:0] adc_a, adc_b, rx_bus_a, rx_bus_b, fa, fb, p;
	logic rx_bus_oe, receive_channel_indicator, indicator_oe;
	logic [7:0] q, v;
	logic [7:0] ifv [7] = '{8'h00, 8'h04, 8'h01, 8'h03, 8'h07, 8'h08, 8'h10};
	int n_fail, compares, n_relock;

	frontend_control_registers #(
		.W        (W),
		.REVISION (REV)
	) u_dut (
		.clk                       (clk),
		.sys_rst                   (sys_rst),
		.sclk                      (sclk),
		.sel_n                     (sel_n),
		.sdio_in                   (sdio_in),
		.sdio_out                  (sdio_out),
		.sdio_oe                   (sdio_oe),
		.serial_data_out_pin       (serial_data_out_pin),
		.serial_data_out_oe        (serial_data_out_oe),
		.dll_relock                (dll_relock),
		.pdn_diff_reference        (pdn_diff_reference),
		.pdn_reference             (pdn_reference),
		.pdn_rx_digital            (pdn_rx_digital),
		.pdn_channel_b             (pdn_channel_b),
		.pdn_channel_a             (pdn_channel_a),
		.pdn_buffer_b              (pdn_buffer_b),
		.pdn_buffer_a              (pdn_buffer_a),
		.pdn_rx_all                (pdn_rx_all),
		.bypass_buffer_a           (bypass_buffer_a),
		.bypass_buffer_b           (bypass_buffer_b),
		.receive_gain_code_a       (receive_gain_code_a),
		.receive_gain_code_b       (receive_gain_code_b),
		.duty_cycle_stabilizer     (duty_cycle_stabilizer),
		.shared_reference          (shared_reference),
		.high_speed_duty_opt       (high_speed_duty_opt),
		.second_output_clock_sel   (second_output_clock_sel),
		.adc_a                     (adc_a),
		.adc_b                     (adc_b),
		.rx_bus_a                  (rx_bus_a),
		.rx_bus_b                  (rx_bus_b),
		.rx_bus_oe                 (rx_bus_oe),
		.receive_channel_indicator (receive_channel_indicator),
		.indicator_oe              (indicator_oe)
	);
	frontend_host u_host (
		.clk                 (clk),
		.sdio_out            (sdio_out),
		.sdio_oe             (sdio_oe),
		.serial_data_out_pin (serial_data_out_pin),
		.serial_data_out_oe  (serial_data_out_oe),
		.sclk                (sclk),
		.sel_n               (sel_n),
		.sdio_in             (sdio_in)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(negedge clk)
		if (dll_relock)
			n_relock++;

	task chk(input string s, input logic [31:0] seen, input logic [31:0] e);
		compares++;
		if (seen !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", s, e, seen);
		end
	endtask : chk

	task wr(input logic [5:0] a, input logic [7:0] d);
		u_host.xfer(1'b0, a, d, 16, q);
	endtask : wr

	task rc(input logic [5:0] a, input logic [7:0] e);
		u_host.xfer(1'b1, a, 8'h00, 16, q);
		chk("read", q, e);
	endtask : rc

	task wrap_up;
		$display("Compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		wrap_up();
	end

	initial
	begin
		{sys_rst, n_fail, compares, n_relock} = {1'b1, 96'd0};
		adc_a = 12'h123;
		adc_b = 12'h456;
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		for (int a = 0; a < 6; a++)
			rc(a[5:0], 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			v = i ? 8'h5a : 8'ha5;
			wr(6'h01, v);
			chk("pdn", {pdn_diff_reference, pdn_reference, pdn_rx_digital,
				pdn_channel_b, pdn_channel_a, pdn_buffer_b, pdn_buffer_a,
				pdn_rx_all}, v);
		end
		wr(6'h02, 8'h94);
		wr(6'h03, 8'h0b);
		chk("setup", {bypass_buffer_a, receive_gain_code_a, bypass_buffer_b,
			receive_gain_code_b}, 12'hd0b);
		wr(6'h03, 8'h1f);
		rc(6'h03, 8'h14);
		// Ones in unassigned bits on purpose: they must not be kept
		wr(6'h04, 8'hff);
		chk("misc", {high_speed_duty_opt, shared_reference,
			duty_cycle_stabilizer}, 3'h7);
		rc(6'h04, 8'h07);
		u_host.xfer(1'b0, 6'h04, 8'h00, 12, q);
		chk("abort", duty_cycle_stabilizer, 1'b1);
		wr(6'h20, 8'h3c);
		rc(6'h20, 8'h00);
		wr(6'h24, 8'hc3);
		rc(6'h24, 8'hc3);
		rc(6'h3f, REV);
		foreach (ifv[i])
		begin
			v = ifv[i];
			wr(6'h05, v);
			fa = adc_a ^ {v[2], 11'h000};
			fb = adc_b ^ {v[2], 11'h000};
			chk("if", {rx_bus_oe, indicator_oe, second_output_clock_sel},
				{{2{!v[4]}}, v[3]});
			for (int k = 0; k < 4 && !v[4]; k++)
			begin
				@(posedge clk);
				#1;
				if (v[0] && k > 0)
					chk("mux", {rx_bus_b, rx_bus_a !== p,
						rx_bus_a === fa || rx_bus_a === fb,
						receive_channel_indicator},
						{12'h000, 2'b11, (rx_bus_a === fa) ^ v[1]});
				else if (!v[0])
					chk("dual", {rx_bus_a, rx_bus_b, receive_channel_indicator},
						{fa, fb, 1'b0});
				p = rx_bus_a;
			end
		end
		u_host.half = 4;
		wr(6'h00, 8'h80);
		rc(6'h02, 8'h94);
		wr(6'h00, 8'h40);
		rc(6'h02, 8'h94);
		wr(6'h00, 8'hc0);
		rc(6'h00, 8'hc0);
		n_relock = 0;
		wr(6'h00, 8'he0);
		chk("relock", n_relock, 1);
		for (int a = 0; a < 6; a++)
			rc(a[5:0], 8'h00);
		wrap_up();
	end
endmodule : frontend_control_registers_test

`default_nettype wire
